/* common/csp_pkg.sv */
// package: register map, fuse codes and timing counts of the clock source and prescaler block
package csp_pkg;
  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [3:0] RC_TRIM_OFS      = 4'h0;
  localparam logic [3:0] CLK_DIV_CTRL_OFS = 4'h4;
  localparam logic [3:0] CLK_STATUS_OFS   = 4'h8;
  localparam logic [3:0] TIMER_OSC_OFS    = 4'hC;
  // ************************************************************
  // fields
  // ************************************************************
  localparam int UNLOCK_BIT      = 7;
  localparam int TRIM_RANGE_BIT  = 7;
  localparam int EXT_SRC_SEL_BIT = 0;
  // ************************************************************
  // reset values and fuse codes
  // ************************************************************
  localparam logic [3:0] DIV_RST_PLAIN    = 4'h0;
  localparam logic [3:0] DIV_RST_BY8      = 4'h3;
  localparam logic [3:0] DIV_MAX_CODE     = 4'h8;
  localparam logic [3:0] SRC_EXT_CLOCK    = 4'h0;
  localparam logic [3:0] SRC_RC_CAL       = 4'h2;
  localparam logic [3:0] SRC_LOW_POWER    = 4'h3;
  localparam logic [1:0] SUT_SHORT        = 2'h0;
  localparam logic [1:0] SUT_MID          = 2'h1;
  localparam logic [1:0] SUT_LONG         = 2'h2;
  localparam logic [7:0] TRIM_FACTORY_DEF = 8'h80;  // arbitrary default
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ          = 50_000_000;
  localparam int UNLOCK_CYCLES   = 4;
  localparam int PD_CK           = 6;
  localparam int RST_CK          = 14;
  localparam int LP_MID_US       = 4000;
  localparam int LP_LONG_US      = 64000;
  localparam int EXT_MID_US      = 4100;
  localparam int EXT_LONG_US     = 65000;
  localparam int LP_MID_CYC      = LP_MID_US * (CLK_HZ / 1_000_000);
  localparam int LP_LONG_CYC     = LP_LONG_US * (CLK_HZ / 1_000_000);
  localparam int EXT_MID_CYC     = EXT_MID_US * (CLK_HZ / 1_000_000);
  localparam int EXT_LONG_CYC    = EXT_LONG_US * (CLK_HZ / 1_000_000);
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : csp_pkg

/* dv/csp_clock_ctrl_assertions.sv */
// checker: bus handshake, clock domain, pin and start-up relations of the clock controller
`timescale 1ns/1ps
`default_nettype none
module csp_clock_ctrl_chk (
  input wire logic       CORE_CLK, SYS_RST, CLOCK_OUTPUT_FUSE, PORT_PIN_OUT,
  input wire logic [3:0] SOURCE_SELECT_FUSES,
  input wire logic       S_AXI_AWVALID, S_AXI_WVALID, S_AXI_AWREADY, S_AXI_WREADY,
  input wire logic       S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY,
  input wire logic       S_AXI_RVALID, SYS_CLK_EN, CORE_CLOCK_DOMAIN,
  input wire logic       PROGRAM_MEMORY_CLOCK_DOMAIN, PERIPHERAL_CLOCK_DOMAIN,
  input wire logic       CONVERTER_CLOCK_DOMAIN, SYSTEM_CLOCK_OUT_PIN,
  input wire logic       TIMER_OSC_ENABLE, TIMER_OSC_EXT_SOURCE_SEL, STARTUP_DONE
);
  import csp_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // saturating count keeps the start-up check valid on long runs
  logic [7:0] since_rst_ff;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) since_rst_ff <= 8'h00;
    else if (since_rst_ff != 8'hFF) since_rst_ff <= since_rst_ff + 8'h01;
  end
  a_write_taken: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY &&
    !S_AXI_BVALID |=> S_AXI_AWREADY && S_AXI_WREADY && S_AXI_BVALID)
    else $error("write not answered in one cycle");
  a_bresp_release: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response held after handshake");
  a_read_answer: assert property ($rose(S_AXI_RVALID) |-> $past(S_AXI_ARVALID) && S_AXI_ARREADY)
    else $error("read answer without request");
  a_domains_equal: assert property (CORE_CLOCK_DOMAIN == PROGRAM_MEMORY_CLOCK_DOMAIN &&
    CORE_CLOCK_DOMAIN == PERIPHERAL_CLOCK_DOMAIN && CORE_CLOCK_DOMAIN == CONVERTER_CLOCK_DOMAIN)
    else $error("clock domains differ");
  a_pin_divided: assert property (CLOCK_OUTPUT_FUSE && !$past(SYS_RST) |->
    SYSTEM_CLOCK_OUT_PIN == CORE_CLOCK_DOMAIN || SYSTEM_CLOCK_OUT_PIN == $past(CORE_CLOCK_DOMAIN))
    else $error("clock pin not the divided clock");
  a_pin_port: assert property (!CLOCK_OUTPUT_FUSE |=> SYSTEM_CLOCK_OUT_PIN == $past(PORT_PIN_OUT))
    else $error("clock pin not the port value");
  a_timer_osc_src: assert property ((!SYS_RST)[*3] |-> TIMER_OSC_ENABLE ==
    (SOURCE_SELECT_FUSES == SRC_RC_CAL))
    else $error("timer oscillator enable wrong");
  a_ext_sel_gated: assert property (TIMER_OSC_EXT_SOURCE_SEL |-> TIMER_OSC_ENABLE)
    else $error("external timer source without timer oscillator");
  a_clk_en_ready: assert property (SYS_CLK_EN |-> STARTUP_DONE)
    else $error("clock enable before start-up");
  a_startup_min: assert property ($rose(STARTUP_DONE) |-> since_rst_ff >= 8'h0E)
    else $error("start-up shorter than minimum");
endmodule : csp_clock_ctrl_chk
bind csp_clock_ctrl csp_clock_ctrl_chk u_chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .CLOCK_OUTPUT_FUSE(CLOCK_OUTPUT_FUSE), .PORT_PIN_OUT(PORT_PIN_OUT),
  .SOURCE_SELECT_FUSES(SOURCE_SELECT_FUSES), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .SYS_CLK_EN(SYS_CLK_EN),
  .CORE_CLOCK_DOMAIN(CORE_CLOCK_DOMAIN),
  .PROGRAM_MEMORY_CLOCK_DOMAIN(PROGRAM_MEMORY_CLOCK_DOMAIN),
  .PERIPHERAL_CLOCK_DOMAIN(PERIPHERAL_CLOCK_DOMAIN),
  .CONVERTER_CLOCK_DOMAIN(CONVERTER_CLOCK_DOMAIN), .SYSTEM_CLOCK_OUT_PIN(SYSTEM_CLOCK_OUT_PIN),
  .TIMER_OSC_ENABLE(TIMER_OSC_ENABLE), .TIMER_OSC_EXT_SOURCE_SEL(TIMER_OSC_EXT_SOURCE_SEL),
  .STARTUP_DONE(STARTUP_DONE));
`default_nettype wire

/* dv/csp_clock_ctrl_tb_top.sv */
// testbench: fuse sweep, start-up timing, register access and prescaler changes
`timescale 1ns/1ps
`default_nettype none
module csp_clock_ctrl_tb_top;
  import csp_pkg::*;
  // shortened long delays, all distinct so each fuse code is told apart
  localparam int LPM = 20, LPL = 30, EXM = 25, EXL = 35, TICK = 4;
  logic clk = 1'b0, rst = 1'b1, rdis = 1'b0, cko = 1'b0, d8 = 1'b0, port = 1'b0;
  logic [3:0] src = 4'h3, awa = 4'h0, ara = 4'h0, cur, c;
  logic [1:0] startup_delay_fuses = 2'h0, bresp, rresp, rr_v, br_v;
  logic [31:0] wd = 32'h0, rdata, rd_d, seed = 32'h2B7F2892;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wrd, bv, arr, rv, clk_en, dm0, dm1, dm2, dm3, cpin, coe, t_en, t_ext, done;
  logic ext, lp, rc, tosc, pv, wake = 1'b0;
  logic [7:0] trim, v;
  logic [3:0] codes [4] = '{4'h8, 4'h9, 4'h1, 4'h0};
  int fails = 0, checks_done = 0, n, tg;
  csp_osc_model #(.HALF(2)) u_osc (.clk(clk), .ext_clk(ext), .lp_clk(lp), .rc_clk(rc),
    .tosc_clk(tosc));
  csp_clock_ctrl #(.LP_MID_CYCLES(LPM), .LP_LONG_CYCLES(LPL), .EXT_MID_CYCLES(EXM),
    .EXT_LONG_CYCLES(EXL)) u_dut (.CORE_CLK(clk), .SYS_RST(rst), .SOURCE_SELECT_FUSES(src),
    .STARTUP_DELAY_FUSES(startup_delay_fuses), .RESET_PIN_DISABLE_FUSE(rdis), .CLOCK_OUTPUT_FUSE(cko),
    .DIVIDE_BY_EIGHT_FUSE(d8), .MAIN_OSC_IN_PIN(ext), .LOW_POWER_OSC_CLK(lp),
    .RC_OSC_CLK(rc), .TIMER_OSC_IN_PIN(tosc), .WAKE_FROM_POWER_DOWN(wake),
    .PORT_PIN_OUT(port), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .SYS_CLK_EN(clk_en), .CORE_CLOCK_DOMAIN(dm0),
    .PROGRAM_MEMORY_CLOCK_DOMAIN(dm1), .PERIPHERAL_CLOCK_DOMAIN(dm2),
    .CONVERTER_CLOCK_DOMAIN(dm3), .SYSTEM_CLOCK_OUT_PIN(cpin), .SYSTEM_CLOCK_OUT_OE(coe),
    .RC_TRIM_OUT(trim), .TIMER_OSC_ENABLE(t_en), .TIMER_OSC_EXT_SOURCE_SEL(t_ext),
    .STARTUP_DONE(done));
  initial begin
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // reserved codes run undivided
  function automatic int gap_of(input logic [3:0] k);
    return (k > 4'h8) ? TICK : TICK << k;
  endfunction : gap_of
  always @(posedge clk) begin
    seed <= lfsr(seed);
    port <= seed[5];
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int t);
    checks_done++;
    if ((g >= e && g - e <= t) !== 1'b1) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic results;
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    br_v = bresp;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0; rd_d = rdata; rr_v = rresp;
  endtask : rd
  task automatic gap;
    n = 0;
    do begin @(posedge clk); n++; end while (clk_en !== 1'b1);
  endtask : gap
  task automatic boot(input logic [3:0] s, input logic [1:0] u, input logic r, input int dly);
    @(posedge clk);
    rst <= 1'b1; src <= s; startup_delay_fuses <= u; rdis <= r; cko <= seed[1]; d8 <= seed[2];
    tg = 0;
    pv = 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      if (i > 1 && cpin !== pv) tg++;
      pv = cpin;
    end
    if (cko) chk("pin_in_reset", 1, tg > 0, 0);
    rst <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (done !== 1'b1);
    chk("startup", 14 + dly, n, 3);
    cur = d8 ? DIV_RST_BY8 : DIV_RST_PLAIN;
    rd(CLK_DIV_CTRL_OFS);
    chk("div_reset", cur, rd_d, 0);
    rd(RC_TRIM_OFS);
    chk("trim_reset", TRIM_FACTORY_DEF, rd_d, 0);
    rd(CLK_STATUS_OFS);
    chk("status", {rdis, cko, 1'b1, cur}, rd_d, 0);
    chk("pin_oe", 1, coe, 0);
  endtask : boot
  initial begin
    boot(4'h3, 2'h0, 1'b0, 0);
    boot(4'h3, 2'h1, 1'b0, LPM);
    boot(4'h3, 2'h2, 1'b0, LPL);
    boot(4'h3, 2'h3, 1'b0, 0);
    boot(4'h0, 2'h0, 1'b0, 0);
    boot(4'h0, 2'h1, 1'b0, EXM);
    boot(4'h0, 2'h2, 1'b0, EXL);
    boot(4'h3, 2'h0, 1'b1, EXM);
    boot(4'h2, 2'h0, 1'b0, 0);
    chk("timer_osc_en", 1, t_en, 0);
    wr(TIMER_OSC_OFS, 32'h1);
    rd(TIMER_OSC_OFS);
    chk("timer_ext_sel", 1, t_ext, 0);
    chk("timer_ext_rd", 32'h1, rd_d, 0);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (done !== 1'b0);
    do begin @(posedge clk); n++; end while (done !== 1'b1);
    chk("pd_startup", PD_CK, n, 3);
    v = seed[7:0];
    wr(RC_TRIM_OFS, {24'h0, v});
    chk("trim_wr_resp", AXI_OKAY, br_v, 0);
    rd(RC_TRIM_OFS);
    chk("trim_rw", v, rd_d, 0);
    chk("trim_out", v, trim, 0);
    rd(4'h2);
    chk("unmapped_resp", AXI_SLVERR, rr_v, 0);
    wr(4'h2, 32'h0);
    chk("unmapped_wr", AXI_SLVERR, br_v, 0);
    wr(CLK_DIV_CTRL_OFS, 32'h81);
    wr(CLK_DIV_CTRL_OFS, 32'h5);
    rd(CLK_DIV_CTRL_OFS);
    chk("unlock_dirty", cur, rd_d, 0);
    wr(CLK_DIV_CTRL_OFS, 32'h80);
    repeat (6) @(posedge clk);
    wr(CLK_DIV_CTRL_OFS, 32'h5);
    rd(CLK_DIV_CTRL_OFS);
    chk("unlock_expired", cur, rd_d, 0);
    codes[2] = 4'(seed % 9);
    for (int i = 0; i < 4; i++) begin
      c = codes[i];
      wr(CLK_DIV_CTRL_OFS, 32'h80);
      wr(CLK_DIV_CTRL_OFS, {28'h0, c});
      rd(CLK_DIV_CTRL_OFS);
      chk("div_code", c, rd_d, 0);
      repeat (4) gap();
      chk("div_period", gap_of(c), n, 0);
    end
    results();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    results();
  end
endmodule : csp_clock_ctrl_tb_top
`default_nettype wire

/* dv/csp_osc_model.sv */
// oscillator model: free-running external, low-power, RC and timer pin clock levels
`timescale 1ns/1ps
`default_nettype none
module csp_osc_model #(
  parameter int HALF = 2
) (
  input  wire logic clk,
  output logic      ext_clk,
  output logic      lp_clk,
  output logic      rc_clk,
  output logic      tosc_clk
);
  int   cnt = 0;
  logic lvl = 1'b0;
  // fixed half period: the source never steps its rate between cycles
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) lvl <= ~lvl;
  end
  assign ext_clk  = lvl;
  assign lp_clk   = lvl;
  assign rc_clk   = lvl;
  assign tosc_clk = ~lvl;
endmodule : csp_osc_model
`default_nettype wire

/* rtl/csp_clock_ctrl.sv */
// module: fuse-driven clock source select, start-up delay, glitch-free prescaler, AXI4-Lite regs
`timescale 1ns/1ps
`default_nettype none
module csp_clock_ctrl #(
  parameter int LP_MID_CYCLES   = csp_pkg::LP_MID_CYC,
  parameter int LP_LONG_CYCLES  = csp_pkg::LP_LONG_CYC,
  parameter int EXT_MID_CYCLES  = csp_pkg::EXT_MID_CYC,
  parameter int EXT_LONG_CYCLES = csp_pkg::EXT_LONG_CYC,
  parameter logic [7:0] FACTORY_TRIM = csp_pkg::TRIM_FACTORY_DEF
) (
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [3:0]  SOURCE_SELECT_FUSES,
  input  wire logic [1:0]  STARTUP_DELAY_FUSES,
  input  wire logic        RESET_PIN_DISABLE_FUSE,
  input  wire logic        CLOCK_OUTPUT_FUSE,
  input  wire logic        DIVIDE_BY_EIGHT_FUSE,
  input  wire logic        MAIN_OSC_IN_PIN,
  input  wire logic        LOW_POWER_OSC_CLK,
  input  wire logic        RC_OSC_CLK,
  input  wire logic        TIMER_OSC_IN_PIN,
  input  wire logic        WAKE_FROM_POWER_DOWN,
  input  wire logic        PORT_PIN_OUT,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             SYS_CLK_EN,
  output logic             CORE_CLOCK_DOMAIN,
  output logic             PROGRAM_MEMORY_CLOCK_DOMAIN,
  output logic             PERIPHERAL_CLOCK_DOMAIN,
  output logic             CONVERTER_CLOCK_DOMAIN,
  output logic             SYSTEM_CLOCK_OUT_PIN,
  output logic             SYSTEM_CLOCK_OUT_OE,
  output logic [7:0]       RC_TRIM_OUT,
  output logic             TIMER_OSC_ENABLE,
  output logic             TIMER_OSC_EXT_SOURCE_SEL,
  output logic             STARTUP_DONE
);
  import csp_pkg::*;

  // ************************************************************
  // fuse capture
  // ************************************************************
  logic [3:0] src_ff;
  logic [1:0] sut_ff;
  logic       rstdis_ff;
  logic       clock_output_fuse_ff;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      src_ff    <= SOURCE_SELECT_FUSES;
      sut_ff    <= STARTUP_DELAY_FUSES;
      rstdis_ff <= RESET_PIN_DISABLE_FUSE;
      clock_output_fuse_ff  <= CLOCK_OUTPUT_FUSE;
    end
  end

  // ************************************************************
  // source clock select
  // ************************************************************
  logic src_clk;
  always_comb begin
    unique case (src_ff)
      SRC_LOW_POWER: src_clk = LOW_POWER_OSC_CLK;
      SRC_EXT_CLOCK: src_clk = MAIN_OSC_IN_PIN;
      default:       src_clk = RC_OSC_CLK;
    endcase
  end

  // ************************************************************
  // start-up delay
  // ************************************************************
  function automatic int reset_extra(input logic [3:0] src, input logic [1:0] startup_delay_fuses,
                                     input logic rstdis);
    int extra;
    extra = 0;
    if (src == SRC_LOW_POWER) begin
      if (startup_delay_fuses == SUT_MID) extra = LP_MID_CYCLES;
      else if (startup_delay_fuses == SUT_LONG) extra = LP_LONG_CYCLES;
    end else begin
      if (startup_delay_fuses == SUT_MID) extra = EXT_MID_CYCLES;
      else if (startup_delay_fuses == SUT_LONG) extra = EXT_LONG_CYCLES;
    end
    if (rstdis && startup_delay_fuses == SUT_SHORT) extra = EXT_MID_CYCLES;
    return extra;
  endfunction

  // a delay counts base clock ticks; the reserved code 11 behaves as the shortest delay
  logic [31:0] su_cnt_ff;
  logic        su_done_ff;
  logic        pd_wait_ff;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      su_cnt_ff  <= 32'h0;
      su_done_ff <= 1'b0;
      pd_wait_ff <= 1'b0;
    end else if (WAKE_FROM_POWER_DOWN && su_done_ff) begin
      su_cnt_ff  <= 32'h0;
      su_done_ff <= 1'b0;
      pd_wait_ff <= 1'b1;
    end else if (!su_done_ff) begin
      if (pd_wait_ff ? (su_cnt_ff >= 32'(PD_CK - 1))
          : (su_cnt_ff >= 32'(RST_CK - 1 + reset_extra(src_ff, sut_ff, rstdis_ff)))) begin
        su_done_ff <= 1'b1;
      end
      su_cnt_ff <= su_cnt_ff + 32'h1;
    end
  end

  // ************************************************************
  // unlock sequence and division select
  // ************************************************************
  logic       unlock_ff;
  logic [2:0] unlock_cnt_ff;
  logic [3:0] div_ff;
  logic       div_init_ff;
  logic       wr_fire;
  logic [7:0] wr_byte;
  assign wr_byte = S_AXI_WDATA[7:0];

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      unlock_ff     <= 1'b0;
      unlock_cnt_ff <= 3'h0;
      div_init_ff   <= 1'b1;
      div_ff        <= DIV_RST_PLAIN;
    end else begin
      if (div_init_ff) begin
        div_init_ff <= 1'b0;
        div_ff      <= DIVIDE_BY_EIGHT_FUSE ? DIV_RST_BY8 : DIV_RST_PLAIN;
      end
      if (unlock_ff) begin
        unlock_cnt_ff <= unlock_cnt_ff + 3'h1;
        if (unlock_cnt_ff == 3'(UNLOCK_CYCLES - 1)) unlock_ff <= 1'b0;
      end
      if (wr_fire && S_AXI_AWADDR == CLK_DIV_CTRL_OFS && S_AXI_WSTRB[0]) begin
        if (wr_byte == 8'h80) begin
          if (!unlock_ff) begin
            unlock_ff     <= 1'b1;
            unlock_cnt_ff <= 3'h0;
          end
        end else if (unlock_ff && !wr_byte[UNLOCK_BIT]) begin
          div_ff    <= wr_byte[3:0];
          unlock_ff <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // glitch-free prescaler
  // ************************************************************
  // the divided clock is an enable pulse over the source tick; a change waits for the old
  // period to finish, so no period is shorter than both old and new ones
  logic       src_d_ff;
  logic       tick;
  logic [7:0] pre_cnt_ff;
  logic [3:0] act_div_ff;
  logic       en_ff;
  logic       ck_ff;
  logic [8:0] period;
  assign tick = src_clk && !src_d_ff;

  function automatic logic [8:0] div_period(input logic [3:0] code);
    if (code > DIV_MAX_CODE) return 9'h1;  // reserved codes act as divide by one
    return 9'h1 << code;
  endfunction
  assign period = div_period(act_div_ff);

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      src_d_ff   <= src_clk;  // tracks the source in reset: no false edge after release
      pre_cnt_ff <= 8'h0;
      act_div_ff <= DIV_RST_PLAIN;
      en_ff      <= 1'b0;
      ck_ff      <= 1'b0;
    end else begin
      src_d_ff <= src_clk;
      en_ff    <= 1'b0;
      if (tick) begin
        if ({1'b0, pre_cnt_ff} >= period - 9'h1) begin
          pre_cnt_ff <= 8'h0;
          en_ff      <= 1'b1;
          ck_ff      <= ~ck_ff;
          act_div_ff <= div_ff;
        end else begin
          pre_cnt_ff <= pre_cnt_ff + 8'h1;
        end
      end
    end
  end

  // ************************************************************
  // clock outputs
  // ************************************************************
  logic tosc_ext_ff;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      SYS_CLK_EN                  <= 1'b0;
      CORE_CLOCK_DOMAIN           <= 1'b0;
      PROGRAM_MEMORY_CLOCK_DOMAIN <= 1'b0;
      PERIPHERAL_CLOCK_DOMAIN     <= 1'b0;
      CONVERTER_CLOCK_DOMAIN      <= 1'b0;
      // the prescaler is held in reset, so with CLOCK_OUTPUT_FUSE set the pin shows the source clock until release
      SYSTEM_CLOCK_OUT_PIN        <= CLOCK_OUTPUT_FUSE ? src_clk : PORT_PIN_OUT;
      SYSTEM_CLOCK_OUT_OE         <= CLOCK_OUTPUT_FUSE;
      TIMER_OSC_ENABLE            <= 1'b0;
      TIMER_OSC_EXT_SOURCE_SEL    <= 1'b0;
      STARTUP_DONE                <= 1'b0;
    end else begin
      SYS_CLK_EN                  <= en_ff && su_done_ff;
      CORE_CLOCK_DOMAIN           <= ck_ff;
      PROGRAM_MEMORY_CLOCK_DOMAIN <= ck_ff;
      PERIPHERAL_CLOCK_DOMAIN     <= ck_ff;
      CONVERTER_CLOCK_DOMAIN      <= ck_ff;
      SYSTEM_CLOCK_OUT_PIN        <= clock_output_fuse_ff ? ck_ff : PORT_PIN_OUT;
      SYSTEM_CLOCK_OUT_OE         <= 1'b1;
      TIMER_OSC_ENABLE            <= (src_ff == SRC_RC_CAL);
      TIMER_OSC_EXT_SOURCE_SEL    <= tosc_ext_ff && (src_ff == SRC_RC_CAL);
      STARTUP_DONE                <= su_done_ff;
    end
  end

  // ************************************************************
  // trim and timer oscillator registers
  // ************************************************************
  logic trim_init_ff;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      RC_TRIM_OUT  <= FACTORY_TRIM;
      trim_init_ff <= 1'b1;
      tosc_ext_ff  <= 1'b0;
    end else begin
      if (trim_init_ff) begin
        trim_init_ff <= 1'b0;
        RC_TRIM_OUT  <= FACTORY_TRIM;
      end else if (wr_fire && S_AXI_AWADDR == RC_TRIM_OFS && S_AXI_WSTRB[0]) begin
        RC_TRIM_OUT <= wr_byte;  // bit 7 is range, 6:0 tune upward
      end
      if (wr_fire && S_AXI_AWADDR == TIMER_OSC_OFS && S_AXI_WSTRB[0]) begin
        tosc_ext_ff <= wr_byte[EXT_SRC_SEL_BIT];
      end
    end
  end

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  // address and data are taken together in one cycle; simpler than holding either alone
  assign wr_fire = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID && !S_AXI_AWREADY;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= AXI_OKAY;
    end else begin
      S_AXI_AWREADY <= wr_fire;
      S_AXI_WREADY  <= wr_fire;
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (S_AXI_AWADDR == RC_TRIM_OFS || S_AXI_AWADDR == CLK_DIV_CTRL_OFS
                        || S_AXI_AWADDR == CLK_STATUS_OFS || S_AXI_AWADDR == TIMER_OSC_OFS)
                        ? AXI_OKAY : AXI_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= AXI_OKAY;
    end else begin
      S_AXI_ARREADY <= 1'b0;
      if (S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b1;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RRESP   <= AXI_OKAY;
        unique case (S_AXI_ARADDR)
          RC_TRIM_OFS:      S_AXI_RDATA <= {24'h0, RC_TRIM_OUT};
          CLK_DIV_CTRL_OFS: S_AXI_RDATA <= {24'h0, unlock_ff, 3'h0, div_ff};
          CLK_STATUS_OFS:   S_AXI_RDATA <= {24'h0, 1'b0, rstdis_ff, clock_output_fuse_ff,
                                            su_done_ff, act_div_ff};
          TIMER_OSC_OFS:    S_AXI_RDATA <= {31'h0, tosc_ext_ff};
          default: begin
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= AXI_SLVERR;
          end
        endcase
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule : csp_clock_ctrl
`default_nettype wire
